// ### sppm_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural SPI master on the far side of the pins, mode 0, MSB first.
module sppm_peer (
    output logic sclk,
    output logic mosi,
    output logic ss_n,
    input wire logic miso
);
    // Between frames the clock stands low and the data line rests at its pull-up.
    initial begin
        sclk = 1'h0;
        mosi = 1'h1;
        ss_n = 1'h1;
    end
    // Sends one byte and captures the returned byte; sel low leaves the select line high.
    task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
        ss_n = !sel;
        #80;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #80;
            sclk = 1'h1;
            rx[i] = miso;
            #80;
            sclk = 1'h0;
        end
        #80;
        ss_n = 1'h1;
        mosi = 1'h1;
        // Keep the select high for a while, so that a following call cannot lower it in the same time step.
        #80;
    endtask
endmodule
`default_nettype wire

// ### sppm_pin_mux.sv
// Behaviour
// - Master drives clock pin; slave receives it.
// - Master-out line direction follows device role.
// - Master data leads capture edge by half-cycle.
// - Master-in line direction follows device role.
// - Unselected slave releases its slave-out line.
// - Slave data leads master capture by half-cycle.
// - Slave accepts transfer only while selected.
// - Each pin may be independent general-purpose I/O.
// - Reset assigns clock, data pins to SPI; code resets all pins to inputs with pull-ups, spi_func_en picks SPI.
// - Port E bits 4-7 gate SPI pull-ups.
// - Port C bit 7 gates home pull-up.
`timescale 1ns/1ps
`default_nettype none

// Receive FIFO between the slave shifter and the core.
module sppm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH]; // Storage words.
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt; // Next slot to fill.
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt; // Next slot to drain.
    logic [AW:0] count_r, count_nxt; // Words held.
    logic push, pop;

    // Advances a pointer with wrap at the depth.
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    // Computes the pointer and count updates.
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
        rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
        count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Registers pointers, count and the written word.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
endmodule

// Pin multiplexer for the first SPI port and the decoder home pin.
module sppm_pin_mux
    import sppm_pkg::*;
#(
    parameter int FIFO_W = FIFO_WIDTH,
    parameter int FIFO_D = FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic master_mode,
    input wire logic [3:0] spi_func_en,
    input wire logic [3:0] port_e_dir,
    input wire logic [3:0] port_e_out,
    input wire logic [7:0] port_e_pullup_enable,
    input wire logic [7:0] port_c_pullup_enable,
    input wire sppm_home_fn_t home_func,
    input wire logic timer_a_channel_three_out,
    input wire logic timer_a_channel_three_oe,
    input wire logic port_c_pin_seven_dir,
    input wire logic port_c_pin_seven_out,
    input wire logic master_sclk,
    input wire logic master_mosi,
    input wire logic [7:0] slave_tx_data,
    input wire logic rx_ready,
    input wire logic spi_serial_clock_pin_in,
    output logic spi_serial_clock_pin_out,
    output logic spi_serial_clock_pin_oe,
    output logic spi_serial_clock_pin_pu,
    input wire logic spi_master_out_pin_in,
    output logic spi_master_out_pin_out,
    output logic spi_master_out_pin_oe,
    output logic spi_master_out_pin_pu,
    input wire logic spi_master_in_pin_in,
    output logic spi_master_in_pin_out,
    output logic spi_master_in_pin_oe,
    output logic spi_master_in_pin_pu,
    input wire logic spi_slave_select_pin_in,
    output logic spi_slave_select_pin_out,
    output logic spi_slave_select_pin_oe,
    output logic spi_slave_select_pin_pu,
    input wire logic home_pin_in,
    output logic home_pin_out,
    output logic home_pin_oe,
    output logic home_pin_pu,
    output logic [3:0] port_e_in,
    output logic master_miso,
    output logic decoder_home_input,
    output logic timer_a_channel_three_in,
    output logic port_c_pin_seven_in,
    output logic slave_selected,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_overrun
);
    logic [4:0] sync1_r; // First synchroniser stage, read only by the second.
    logic [4:0] sync2_r; // Second synchroniser stage.
    logic sclk_prev_r; // Previous synchronised clock level for edge finding.
    logic [3:0] oe_r, oe_nxt; // SPI pin output enables.
    logic [3:0] out_r, out_nxt; // SPI pin output levels.
    logic [3:0] pu_r, pu_nxt; // SPI pin pull-up enables.
    logic home_oe_r, home_oe_nxt, home_out_r, home_out_nxt, home_pu_r, home_pu_nxt;
    logic [4:0] in_r; // Registered pin levels handed to the core.
    logic sel_r, sel_nxt; // Device is an addressed slave.
    logic [7:0] rx_sh_r, rx_sh_nxt; // Slave receive shifter.
    logic [7:0] tx_sh_r, tx_sh_nxt; // Slave transmit shifter.
    logic [2:0] cnt_r, cnt_nxt; // Bits received in the current byte.
    logic ovr_r, ovr_nxt; // Sticky overrun, set when the FIFO is full.
    logic push_valid, push_ready;
    logic [7:0] push_data;
    logic sclk_s, rise, fall;
    logic [7:0] fifo_out_data;
    logic fifo_out_valid;

    // Brings every pin level into the core clock domain through two flops.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_r <= 5'h1F;
            sync2_r <= 5'h1F;
            sclk_prev_r <= 1'h1;
        end else begin
            sync1_r <= {home_pin_in, spi_slave_select_pin_in, spi_master_in_pin_in,
                        spi_master_out_pin_in, spi_serial_clock_pin_in};
            sync2_r <= sync1_r;
            sclk_prev_r <= sync2_r[PIN_SCLK];
        end
    end

    assign sclk_s = sync2_r[PIN_SCLK];
    assign rise = sclk_s && !sclk_prev_r;
    assign fall = !sclk_s && sclk_prev_r;

    // Chooses direction, level and pull-up for every pin.
    always_comb begin
        // General-purpose function is the fallback for each pin on its own.
        oe_nxt = port_e_dir;
        out_nxt = port_e_out;
        if (spi_func_en[PIN_SCLK]) begin
            // Master drives the clock; a slave leaves it as an input.
            oe_nxt[PIN_SCLK] = master_mode;
            out_nxt[PIN_SCLK] = master_sclk;
        end
        if (spi_func_en[PIN_MOSI]) begin
            // Clock and data share one register stage, so the engine's half-cycle lead survives.
            oe_nxt[PIN_MOSI] = master_mode;
            out_nxt[PIN_MOSI] = master_mosi;
        end
        if (spi_func_en[PIN_MISO]) begin
            // Only an addressed slave drives; otherwise the line floats for others.
            oe_nxt[PIN_MISO] = !master_mode && sel_r;
            out_nxt[PIN_MISO] = tx_sh_r[7];
        end
        if (spi_func_en[PIN_SS]) begin
            // Slave select is only ever an input.
            oe_nxt[PIN_SS] = 1'b0;
            out_nxt[PIN_SS] = 1'b0;
        end
        pu_nxt = port_e_pullup_enable[PE_SS_BIT:PE_SCLK_BIT];
        home_pu_nxt = port_c_pullup_enable[PC_HOME_BIT];
        unique case (home_func)
            HOME_FN_TIMER: begin
                home_oe_nxt = timer_a_channel_three_oe;
                home_out_nxt = timer_a_channel_three_out;
            end
            HOME_FN_GPIO: begin
                home_oe_nxt = port_c_pin_seven_dir;
                home_out_nxt = port_c_pin_seven_out;
            end
            default: begin
                // The decoder input and any illegal code leave the pin undriven.
                home_oe_nxt = 1'b0;
                home_out_nxt = 1'b0;
            end
        endcase
    end

    // Registers pin controls; reset keeps every pin an input with pull-up.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oe_r <= {4{PIN_OE_RST}};
            out_r <= {4{PIN_OUT_RST}};
            pu_r <= {4{PIN_PU_RST}};
            home_oe_r <= PIN_OE_RST;
            home_out_r <= PIN_OUT_RST;
            home_pu_r <= PIN_PU_RST;
            in_r <= 5'h1F;
        end else begin
            oe_r <= oe_nxt;
            out_r <= out_nxt;
            pu_r <= pu_nxt;
            home_oe_r <= home_oe_nxt;
            home_out_r <= home_out_nxt;
            home_pu_r <= home_pu_nxt;
            in_r <= sync2_r;
        end
    end

    // Slave shifter: samples on rising clock, launches on falling clock.
    always_comb begin
        sel_nxt = !master_mode && spi_func_en[PIN_SS] && !sync2_r[PIN_SS];
        rx_sh_nxt = rx_sh_r;
        tx_sh_nxt = tx_sh_r;
        cnt_nxt = cnt_r;
        ovr_nxt = ovr_r;
        push_valid = 1'b0;
        push_data = {rx_sh_r[6:0], sync2_r[PIN_MOSI]};
        if (!sel_r) begin
            // Idle: preload the reply so its first bit is out before the first edge.
            cnt_nxt = BIT_CNT_RST;
            tx_sh_nxt = slave_tx_data;
        end else if (rise) begin
            // Bits are accepted only while the select input is held low.
            rx_sh_nxt = push_data;
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == BIT_CNT_LAST) begin
                push_valid = 1'b1;
                // A full FIFO drops the byte and marks it lost.
                if (!push_ready) begin
                    ovr_nxt = 1'b1;
                end
            end
        end else if (fall) begin
            // Next reply bit appears half a clock ahead of the master's sample.
            tx_sh_nxt = (cnt_r == BIT_CNT_RST) ? slave_tx_data : {tx_sh_r[6:0], 1'b0};
        end
    end

    // Registers the slave shifter state.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_r <= 1'b0;
            rx_sh_r <= BYTE_RST;
            tx_sh_r <= BYTE_RST;
            cnt_r <= BIT_CNT_RST;
            ovr_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_sh_r <= tx_sh_nxt;
            cnt_r <= cnt_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    sppm_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(rx_ready),
        .out_data(fifo_out_data)
    );

    assign rx_valid = fifo_out_valid;
    assign rx_data = fifo_out_data;
    assign rx_overrun = ovr_r;
    assign slave_selected = sel_r;
    assign spi_serial_clock_pin_out = out_r[PIN_SCLK];
    assign spi_serial_clock_pin_oe = oe_r[PIN_SCLK];
    assign spi_serial_clock_pin_pu = pu_r[PIN_SCLK];
    assign spi_master_out_pin_out = out_r[PIN_MOSI];
    assign spi_master_out_pin_oe = oe_r[PIN_MOSI];
    assign spi_master_out_pin_pu = pu_r[PIN_MOSI];
    assign spi_master_in_pin_out = out_r[PIN_MISO];
    assign spi_master_in_pin_oe = oe_r[PIN_MISO];
    assign spi_master_in_pin_pu = pu_r[PIN_MISO];
    assign spi_slave_select_pin_out = out_r[PIN_SS];
    assign spi_slave_select_pin_oe = oe_r[PIN_SS];
    assign spi_slave_select_pin_pu = pu_r[PIN_SS];
    assign home_pin_out = home_out_r;
    assign home_pin_oe = home_oe_r;
    assign home_pin_pu = home_pu_r;
    assign port_e_in = in_r[3:0];
    assign master_miso = in_r[PIN_MISO];
    assign decoder_home_input = in_r[4];
    assign timer_a_channel_three_in = in_r[4];
    assign port_c_pin_seven_in = in_r[4];
endmodule

`default_nettype wire

// ### sppm_pin_mux_props.sv
`timescale 1ns/1ps
`default_nettype none
// Ties the directions of the clock, data and home pins and the clock and master-out pull-ups to the inputs that select them.
module sppm_pin_mux_props
    import sppm_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic master_mode,
    input wire logic [3:0] spi_func_en,
    input wire logic [3:0] port_e_dir,
    input wire logic [7:0] port_e_pullup_enable,
    input wire sppm_home_fn_t home_func,
    input wire logic timer_a_channel_three_oe,
    input wire logic port_c_pin_seven_dir,
    input wire logic slave_selected,
    input wire logic spi_serial_clock_pin_oe,
    input wire logic spi_serial_clock_pin_pu,
    input wire logic spi_master_out_pin_oe,
    input wire logic spi_master_out_pin_pu,
    input wire logic spi_master_in_pin_oe,
    input wire logic home_pin_oe
);
    logic [1:0] run_r; // Edges seen since reset, held at three.
    logic [1:0] run_nxt; // Next value of the edge count.
    // Past values only describe live controls once three edges have passed.
    always_comb begin
        run_nxt = (run_r == 2'h3) ? run_r : run_r + 2'h1;
    end
    always_ff @(posedge core_clk) begin
        run_r <= sys_rst ? 2'h0 : run_nxt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // The mux has settled from controls that were set after reset.
    sequence s_live;
        run_r == 2'h3;
    endsequence
    chk_clock_dir: assert property (s_live |-> !$past(spi_func_en[0]) ||
        spi_serial_clock_pin_oe == $past(master_mode)) else $error("clock pin direction wrong");
    chk_mosi_dir: assert property (s_live |-> !$past(spi_func_en[1]) ||
        spi_master_out_pin_oe == $past(master_mode)) else $error("master-out direction wrong");
    chk_miso_release: assert property (s_live ##0 $past(spi_func_en[2]) |->
        spi_master_in_pin_oe == (!$past(master_mode) && $past(slave_selected))) else $error("master-in drive wrong");
    chk_select_gate: assert property (s_live ##0 slave_selected |->
        $past(spi_func_en[3]) && !$past(master_mode)) else $error("selected outside slave role");
    chk_gpio_dir: assert property (s_live ##0 !$past(spi_func_en[0]) |->
        spi_serial_clock_pin_oe == $past(port_e_dir[0])) else $error("gpio direction wrong");
    chk_pullup_map: assert property (s_live |->
        {spi_master_out_pin_pu, spi_serial_clock_pin_pu} == $past(port_e_pullup_enable[5:4])) else $error("pull-up wrong");
    chk_home_func: assert property (s_live |-> home_pin_oe == ($past(home_func) == HOME_FN_TIMER ?
        $past(timer_a_channel_three_oe) : $past(home_func) == HOME_FN_GPIO && $past(port_c_pin_seven_dir)))
        else $error("home pin drive wrong");
    chk_reset_quiet: assert property ($fell(sys_rst) |-> !spi_serial_clock_pin_oe &&
        !spi_master_out_pin_oe && !spi_master_in_pin_oe && spi_master_out_pin_pu) else $error("reset state wrong");
endmodule
bind sppm_pin_mux sppm_pin_mux_props u_props (.*);
`default_nettype wire

// ### sppm_pin_mux_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the SPI pin multiplexer with an SPI master peer.
module sppm_pin_mux_test
    import sppm_pkg::*;
();
    logic core_clk, sys_rst = 1'h1, master_mode = 1'h0, rx_ready = 1'h0, master_sclk = 1'h0, master_mosi = 1'h0;
    logic timer_a_channel_three_out = 1'h1, timer_a_channel_three_oe = 1'h1, miso_drv = 1'h1, home_drv = 1'h0;
    logic port_c_pin_seven_dir = 1'h1, port_c_pin_seven_out = 1'h0;
    logic [3:0] spi_func_en = 4'hF, port_e_dir = 4'h0, port_e_out = 4'h0, port_e_in;
    logic [7:0] port_e_pullup_enable = 8'hFF, port_c_pullup_enable = 8'hFF, slave_tx_data = 8'hA5, rx_data;
    sppm_home_fn_t home_func = HOME_FN_DECODER;
    logic master_miso, decoder_home_input, slave_selected, rx_valid, rx_overrun, p_sclk, p_mosi, p_ss_n;
    logic spi_serial_clock_pin_in, spi_serial_clock_pin_out, spi_serial_clock_pin_oe, spi_serial_clock_pin_pu;
    logic spi_master_out_pin_in, spi_master_out_pin_out, spi_master_out_pin_oe, spi_master_out_pin_pu;
    logic spi_master_in_pin_in, spi_master_in_pin_out, spi_master_in_pin_oe, spi_master_in_pin_pu;
    logic spi_slave_select_pin_in, spi_slave_select_pin_out, spi_slave_select_pin_oe;
    logic home_pin_in, home_pin_out, home_pin_oe, home_pin_pu;
    int err_total = 0, n_tests = 0;
    // Each wire shows the device when it drives, otherwise the far side or the pull-up.
    assign spi_serial_clock_pin_in = spi_serial_clock_pin_oe ? spi_serial_clock_pin_out : p_sclk;
    assign spi_master_out_pin_in = spi_master_out_pin_oe ? spi_master_out_pin_out : p_mosi;
    assign spi_master_in_pin_in = spi_master_in_pin_oe ? spi_master_in_pin_out : miso_drv;
    assign spi_slave_select_pin_in = spi_slave_select_pin_oe ? spi_slave_select_pin_out : p_ss_n;
    assign home_pin_in = home_pin_oe ? home_pin_out : home_drv;
    sppm_pin_mux #(.FIFO_D(8)) uut (.*, .port_c_pin_seven_in(), .timer_a_channel_three_in(),
        .spi_slave_select_pin_pu());
    sppm_peer peer (.sclk(p_sclk), .mosi(p_mosi), .ss_n(p_ss_n), .miso(spi_master_in_pin_in));
    // The core clock toggles every 5 ns.
    initial begin
        core_clk = 1'h0;
        forever begin
            #5 core_clk = ~core_clk;
        end
    end
    // Waits for edges and steps just past the last one, where inputs change.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Compares one result and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Waits a bounded time for a received byte, compares it and takes it.
    task automatic pop(input logic [7:0] exp);
        int k;
        for (k = 0; k < 300 && rx_valid !== 1'h1; k++) begin
            tick(1);
        end
        if (k == 300) begin
            err_total++;
            $display("Error at %0t: no byte arrived", $time);
            wrap_up();
        end
        chk(rx_data, exp);
        rx_ready = 1'h1;
        tick(1);
        rx_ready = 1'h0;
    endtask
    // Holds reset for six edges and checks the quiet pin state meanwhile.
    task automatic t_reset;
        sys_rst = 1'h1;
        tick(6);
        chk({5'h00, spi_serial_clock_pin_oe, spi_master_out_pin_oe, spi_master_in_pin_oe}, 8'h00);
        chk({6'h00, spi_serial_clock_pin_pu, home_pin_pu}, 8'h03);
        sys_rst = 1'h0;
        tick(2);
    endtask
    // Master role: clock and master-out drive, master-in is heard by the core.
    task automatic t_master;
        master_mode = 1'h1;
        master_sclk = 1'h1;
        master_mosi = 1'h1;
        miso_drv = 1'h0;
        tick(4);
        chk({4'h0, spi_slave_select_pin_oe, spi_serial_clock_pin_oe, spi_master_out_pin_oe, spi_master_in_pin_oe}, 8'h06);
        chk({6'h00, spi_serial_clock_pin_out, spi_master_out_pin_out}, 8'h03);
        chk({7'h00, master_miso}, 8'h00);
        master_mode = 1'h0;
        master_sclk = 1'h0;
        miso_drv = 1'h1;
        tick(4);
    endtask
    // Slave role: one selected byte both ways, then a byte sent while not selected.
    task automatic t_slave;
        logic [7:0] rx;
        peer.xfer(8'h3C, 1'h1, rx);
        chk(rx, 8'hA5);
        pop(8'h3C);
        tick(6);
        chk({7'h00, spi_master_in_pin_oe}, 8'h00);
        peer.xfer(8'h5A, 1'h0, rx);
        tick(20);
        chk({7'h00, rx_valid}, 8'h00);
    endtask
    // Fills the receive buffer past full while the core stalls, then drains it.
    task automatic t_fifo;
        logic [7:0] rx;
        slave_tx_data = 8'h69;
        for (int i = 0; i < 9; i++) begin
            peer.xfer(8'h10 + 8'(i), 1'h1, rx);
        end
        tick(6);
        chk(rx, 8'h69);
        chk({7'h00, rx_overrun}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            pop(8'h10 + 8'(i));
        end
        tick(2);
        chk({7'h00, rx_valid}, 8'h00);
    endtask
    // Walks the home pin through its three functions.
    task automatic t_home;
        for (int f = 0; f < 3; f++) begin
            home_func = sppm_home_fn_t'(f[1:0]);
            tick(4);
            chk({6'h00, home_pin_oe, decoder_home_input}, f == 0 ? 8'h00 : f == 1 ? 8'h03 : 8'h02);
        end
    endtask
    // General-purpose use of the SPI pins with mixed directions and pull-ups.
    task automatic t_gpio_pull;
        spi_func_en = 4'h0;
        port_e_dir = 4'h5;
        port_e_pullup_enable = 8'hAF;
        port_c_pullup_enable = 8'h7F;
        tick(5);
        chk({5'h00, spi_master_in_pin_oe, spi_master_out_pin_oe, spi_serial_clock_pin_oe}, 8'h05);
        chk({4'h0, port_e_in}, 8'h0A);
        chk({5'h00, spi_master_in_pin_pu, spi_master_out_pin_pu, spi_serial_clock_pin_pu}, 8'h02);
        chk({7'h00, home_pin_pu}, 8'h00);
    endtask
    // Main sequence, ending with a reset in mid-run.
    initial begin
        t_reset();
        t_master();
        t_slave();
        t_fifo();
        t_home();
        t_gpio_pull();
        t_reset();
        wrap_up();
    end
endmodule
`default_nettype wire

// ### sppm_pkg.sv
package sppm_pkg;

    // Positions of the SPI pins inside the port E pull-up enable word.
    localparam int PE_SCLK_BIT = 4;
    localparam int PE_MOSI_BIT = 5;
    localparam int PE_MISO_BIT = 6;
    localparam int PE_SS_BIT = 7;

    // Position of the home pin inside the port C pull-up enable word.
    localparam int PC_HOME_BIT = 7;

    // Index of each SPI pin inside the 4-bit per-pin control vectors.
    localparam int PIN_SCLK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SS = 3;

    // Reset values of the registered pin controls, synchroniser and slave shifter, plus the last bit count.
    localparam logic PIN_OE_RST = 1'h0;
    localparam logic PIN_OUT_RST = 1'h0;
    localparam logic PIN_PU_RST = 1'h1;
    localparam logic [2:0] SYNC_RST = 3'h7;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;

    // FIFO geometry defaults.
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    // Functions that the home pin may take; the decoder input is the reset default.
    typedef enum logic [1:0] {
        HOME_FN_DECODER,
        HOME_FN_TIMER,
        HOME_FN_GPIO
    } sppm_home_fn_t;

endpackage
